//--- logic/pin_mux_pkg.sv
// Shared constants and function codes for the digital pin multiplexer
package pin_mux_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Per-pin function codes and PLL reference source codes (one-hot)
    typedef enum logic [2:0] {
        DIN_AUDIO    = 3'h1,
        DIN_MIC_DATA = 3'h2,
        DIN_PLL_REF  = 3'h4
    } din_func_t;

    typedef enum logic [1:0] {
        DOUT_AUDIO = 2'h1,
        DOUT_GPO   = 2'h2
    } dout_func_t;

    typedef enum logic [2:0] {
        THREE_IDLE     = 3'h1,
        THREE_MIC_DATA = 3'h2,
        THREE_SEC_BCLK = 3'h4
    } three_func_t;

    typedef enum logic [2:0] {
        FOUR_IDLE    = 3'h1,
        FOUR_GPO     = 3'h2,
        FOUR_MIC_CLK = 3'h4
    } four_func_t;

    typedef enum logic [5:0] {
        GPIO_IDLE     = 6'h01,
        GPIO_GPO      = 6'h02,
        GPIO_MIC_CLK  = 6'h04,
        GPIO_MIC_DATA = 6'h08,
        GPIO_SEC_BCLK = 6'h10,
        GPIO_PLL_REF  = 6'h20
    } gpio_func_t;

    typedef enum logic [3:0] {
        PLL_MCLK = 4'h1,
        PLL_BCLK = 4'h2,
        PLL_DIN  = 4'h4,
        PLL_GPIO = 4'h8
    } pll_src_t;

    ////////////////////////////////////////////////////////////////////////////
    // Values after reset
    localparam din_func_t  DIN_FUNC_RESET  = DIN_AUDIO;
    localparam dout_func_t DOUT_FUNC_RESET = DOUT_AUDIO;
    localparam three_func_t THREE_FUNC_RESET = THREE_IDLE;
    localparam four_func_t  FOUR_FUNC_RESET  = FOUR_IDLE;
    localparam gpio_func_t GPIO_FUNC_RESET = GPIO_IDLE;
    localparam pll_src_t   PLL_SRC_RESET   = PLL_MCLK;
    localparam logic [2:0] GPO_LEVEL_RESET = 3'h0;
    localparam logic       POWER_RESET     = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // Level bit positions of the three general-purpose outputs
    localparam int GPO_DOUT_BIT = 0;
    localparam int GPO_FOUR_BIT = 1;
    localparam int GPO_GPIO_BIT = 2;

    // Legal code check for any selection field
    function automatic logic legal_code(input logic [5:0] code);
        return $onehot(code);
    endfunction

endpackage

//--- logic/pin_output_stage.sv
// Registered output driver for one reassignable pin
`timescale 1ns/1ps
`default_nettype none

module pin_output_stage (
    input  wire logic i_clk,
    input  wire logic i_reset,
    input  wire logic i_drive,
    input  wire logic i_level,
    output logic      o_pin,
    output logic      o_oe_n
);

    typedef struct packed {
        logic pin;
        logic oe_n;
    } stage_t;

    stage_t state;
    stage_t next_state;

    always_comb begin
        next_state      = state;
        next_state.oe_n = ~i_drive;
        next_state.pin  = i_drive & i_level;
    end

    // Released and low after reset
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state <= '{pin: 1'b0, oe_n: 1'b1};
        end else begin
            state <= next_state;
        end
    end

    assign o_pin  = state.pin;
    assign o_oe_n = state.oe_n;

endmodule // pin_output_stage

`default_nettype wire

//--- logic/multifunction_pin_mux.sv
// Digital pin function allocation with control-bus select and analog power gating
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - The interface-select pin decides whether the two control-bus pins act as I2C or SPI.
// - Reset and interface-select pins have fixed functions that configuration cannot change.
// - Every reassignable pin starts in its default function and changes only on a write.
// - Pin functions are chosen by configuration writes from the host.
// - The PLL reference comes from master clock, bit clock, serial data in or the GP pin.
// - All analog blocks are powered down after reset and powered up in any combination by a host write.
// - Microphone data may come from serial data in, the mic-data pin or the GP pin.
// - Microphone clock goes out only on the mic-clock pin or the GP pin.
// - Secondary port bit clock comes from the mic-data pin or the GP pin.
// - Three general-purpose outputs sit on serial data out, mic-clock pin and GP pin.
// - An exclusive pin carries only its selected function and no other.
module multifunction_pin_mux #(
    parameter int NUM_ANALOG_BLOCKS = 4
) (
    input  wire logic                           i_clk,
    input  wire logic                           i_reset,
    input  wire logic                           i_reset_pin_n,
    input  wire logic                           i_spi_select,
    input  wire logic                           i_ctl_clk_pin,
    input  wire logic                           i_ctl_data_pin,
    input  wire logic                           i_cfg_write,
    input  wire pin_mux_pkg::din_func_t         i_cfg_din_func,
    input  wire pin_mux_pkg::dout_func_t        i_cfg_dout_func,
    input  wire pin_mux_pkg::three_func_t       i_cfg_three_func,
    input  wire pin_mux_pkg::four_func_t        i_cfg_four_func,
    input  wire pin_mux_pkg::gpio_func_t        i_cfg_gpio_func,
    input  wire pin_mux_pkg::pll_src_t          i_cfg_pll_src,
    input  wire logic [2:0]                     i_cfg_gpo_level,
    input  wire logic [NUM_ANALOG_BLOCKS-1:0]   i_cfg_power_up,
    input  wire logic                           i_mclk_pin,
    input  wire logic                           i_bclk_pin,
    input  wire logic                           i_din_pin,
    input  wire logic                           i_three_pin,
    input  wire logic                           i_gpio_pin,
    input  wire logic                           i_audio_dout,
    input  wire logic                           i_mic_clk,
    output logic                                o_i2c_mode,
    output logic                                o_i2c_scl,
    output logic                                o_i2c_sda,
    output logic                                o_serial_port_chip_select_n,
    output logic                                o_spi_mosi,
    output logic                                o_pll_ref,
    output logic                                o_audio_din,
    output logic                                o_mic_data,
    output logic                                o_sec_bclk,
    output logic                                o_dout_pin,
    output logic                                o_dout_oe_n,
    output logic                                o_four_pin,
    output logic                                o_four_oe_n,
    output logic                                o_gpio_pin,
    output logic                                o_gpio_oe_n,
    output logic [NUM_ANALOG_BLOCKS-1:0]        o_analog_power_en
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        pin_mux_pkg::din_func_t       din_func;
        pin_mux_pkg::dout_func_t      dout_func;
        pin_mux_pkg::three_func_t     three_func;
        pin_mux_pkg::four_func_t      four_func;
        pin_mux_pkg::gpio_func_t      gpio_func;
        pin_mux_pkg::pll_src_t        pll_src;
        logic [2:0]                   gpo_level;
        logic [NUM_ANALOG_BLOCKS-1:0] power_en;
        logic                         i2c_mode;
        logic                         i2c_scl;
        logic                         i2c_sda;
        logic                         cs_n;
        logic                         mosi;
        logic                         pll_ref;
        logic                         audio_din;
        logic                         mic_data;
        logic                         sec_bclk;
    } mux_state_t;

    mux_state_t state;
    mux_state_t next_state;
    logic       rst;
    logic       dout_drive;
    logic       dout_level;
    logic       four_drive;
    logic       four_level;
    logic       gpio_drive;
    logic       gpio_level;

    // Hardware reset pin always resets, never remapped
    assign rst = i_reset | ~i_reset_pin_n;

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        next_state = state;
        // Selection changes only on a host write with a legal code
        if (i_cfg_write) begin
            if (pin_mux_pkg::legal_code({3'h0, i_cfg_din_func})) begin
                next_state.din_func = i_cfg_din_func;
            end
            if (pin_mux_pkg::legal_code({4'h0, i_cfg_dout_func})) begin
                next_state.dout_func = i_cfg_dout_func;
            end
            if (pin_mux_pkg::legal_code({3'h0, i_cfg_three_func})) begin
                next_state.three_func = i_cfg_three_func;
            end
            if (pin_mux_pkg::legal_code({3'h0, i_cfg_four_func})) begin
                next_state.four_func = i_cfg_four_func;
            end
            if (pin_mux_pkg::legal_code(i_cfg_gpio_func)) begin
                next_state.gpio_func = i_cfg_gpio_func;
            end
            if (pin_mux_pkg::legal_code({2'h0, i_cfg_pll_src})) begin
                next_state.pll_src = i_cfg_pll_src;
            end
            next_state.gpo_level = i_cfg_gpo_level;
            next_state.power_en  = i_cfg_power_up;
        end

        // Control-bus personality from the select pin
        next_state.i2c_mode = ~i_spi_select;
        next_state.i2c_scl  = i_spi_select ? 1'b1 : i_ctl_clk_pin;
        next_state.i2c_sda  = i_spi_select ? 1'b1 : i_ctl_data_pin;
        next_state.cs_n     = i_spi_select ? i_ctl_clk_pin : 1'b1;
        next_state.mosi     = i_spi_select ? i_ctl_data_pin : 1'b0;

        // PLL reference source
        unique case (state.pll_src)
            pin_mux_pkg::PLL_MCLK: next_state.pll_ref = i_mclk_pin;
            pin_mux_pkg::PLL_BCLK: next_state.pll_ref = i_bclk_pin;
            pin_mux_pkg::PLL_DIN:
                next_state.pll_ref = (state.din_func == pin_mux_pkg::DIN_PLL_REF) & i_din_pin;
            pin_mux_pkg::PLL_GPIO:
                next_state.pll_ref = (state.gpio_func == pin_mux_pkg::GPIO_PLL_REF) & i_gpio_pin;
            default: next_state.pll_ref = 1'b0;
        endcase

        // Exclusive input functions, inactive when unassigned
        next_state.audio_din = (state.din_func == pin_mux_pkg::DIN_AUDIO) & i_din_pin;
        if (state.din_func == pin_mux_pkg::DIN_MIC_DATA) begin
            next_state.mic_data = i_din_pin;
        end else if (state.three_func == pin_mux_pkg::THREE_MIC_DATA) begin
            next_state.mic_data = i_three_pin;
        end else if (state.gpio_func == pin_mux_pkg::GPIO_MIC_DATA) begin
            next_state.mic_data = i_gpio_pin;
        end else begin
            next_state.mic_data = 1'b0;
        end
        if (state.three_func == pin_mux_pkg::THREE_SEC_BCLK) begin
            next_state.sec_bclk = i_three_pin;
        end else if (state.gpio_func == pin_mux_pkg::GPIO_SEC_BCLK) begin
            next_state.sec_bclk = i_gpio_pin;
        end else begin
            next_state.sec_bclk = 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (rst) begin
            state           <= '0;
            state.din_func  <= pin_mux_pkg::DIN_FUNC_RESET;
            state.dout_func <= pin_mux_pkg::DOUT_FUNC_RESET;
            state.three_func <= pin_mux_pkg::THREE_FUNC_RESET;
            state.four_func <= pin_mux_pkg::FOUR_FUNC_RESET;
            state.gpio_func <= pin_mux_pkg::GPIO_FUNC_RESET;
            state.pll_src   <= pin_mux_pkg::PLL_SRC_RESET;
            state.gpo_level <= pin_mux_pkg::GPO_LEVEL_RESET;
            state.power_en  <= {NUM_ANALOG_BLOCKS{pin_mux_pkg::POWER_RESET}};
            state.i2c_mode  <= 1'b1;
            state.i2c_scl   <= 1'b1;
            state.i2c_sda   <= 1'b1;
            state.cs_n      <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output pins

    // Serial data out: audio or first general-purpose output
    assign dout_drive = 1'b1;
    assign dout_level = (state.dout_func == pin_mux_pkg::DOUT_GPO) ?
                        state.gpo_level[pin_mux_pkg::GPO_DOUT_BIT] : i_audio_dout;
    // Mic-clock pin: second output or mic clock
    assign four_drive = state.four_func != pin_mux_pkg::FOUR_IDLE;
    assign four_level = (state.four_func == pin_mux_pkg::FOUR_MIC_CLK) ?
                        i_mic_clk : state.gpo_level[pin_mux_pkg::GPO_FOUR_BIT];
    // GP pin: third output or mic clock
    assign gpio_drive = (state.gpio_func == pin_mux_pkg::GPIO_GPO) |
                        (state.gpio_func == pin_mux_pkg::GPIO_MIC_CLK);
    assign gpio_level = (state.gpio_func == pin_mux_pkg::GPIO_MIC_CLK) ?
                        i_mic_clk : state.gpo_level[pin_mux_pkg::GPO_GPIO_BIT];

    pin_output_stage u_dout_stage (
        .i_clk   (i_clk),
        .i_reset (rst),
        .i_drive (dout_drive),
        .i_level (dout_level),
        .o_pin   (o_dout_pin),
        .o_oe_n  (o_dout_oe_n)
    );

    pin_output_stage u_four_stage (
        .i_clk   (i_clk),
        .i_reset (rst),
        .i_drive (four_drive),
        .i_level (four_level),
        .o_pin   (o_four_pin),
        .o_oe_n  (o_four_oe_n)
    );

    pin_output_stage u_gpio_stage (
        .i_clk   (i_clk),
        .i_reset (rst),
        .i_drive (gpio_drive),
        .i_level (gpio_level),
        .o_pin   (o_gpio_pin),
        .o_oe_n  (o_gpio_oe_n)
    );

    assign o_i2c_mode                  = state.i2c_mode;
    assign o_i2c_scl                   = state.i2c_scl;
    assign o_i2c_sda                   = state.i2c_sda;
    assign o_serial_port_chip_select_n = state.cs_n;
    assign o_spi_mosi                  = state.mosi;
    assign o_pll_ref                   = state.pll_ref;
    assign o_audio_din                 = state.audio_din;
    assign o_mic_data                  = state.mic_data;
    assign o_sec_bclk                  = state.sec_bclk;
    assign o_analog_power_en           = state.power_en;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (rst);

    sequence seq_mic_clk_on_four;
        state.four_func == pin_mux_pkg::FOUR_MIC_CLK;
    endsequence

    sequence seq_legal_gpio_write;
        i_cfg_write && pin_mux_pkg::legal_code(i_cfg_gpio_func);
    endsequence

    AST_SPI_MODE: assert property (i_spi_select |=>
        !o_i2c_mode && o_spi_mosi == $past(i_ctl_data_pin))
        else $error("spi select not honoured");
    AST_I2C_ROUTE: assert property (!i_spi_select |=>
        o_i2c_scl == $past(i_ctl_clk_pin) && o_serial_port_chip_select_n)
        else $error("i2c routing wrong");
    AST_RESET_DEFAULTS: assert property (disable iff (1'b0) rst |=>
        state.din_func == pin_mux_pkg::DIN_AUDIO && state.gpio_func == pin_mux_pkg::GPIO_IDLE
        && o_analog_power_en == '0)
        else $error("defaults not restored");
    AST_HOLD_SELECTION: assert property (!i_cfg_write |=>
        $stable(state.gpio_func) && $stable(state.din_func))
        else $error("selection changed without write");
    AST_WRITE_TAKES: assert property (seq_legal_gpio_write |=>
        state.gpio_func == $past(i_cfg_gpio_func))
        else $error("gpio function write lost");
    AST_PLL_MCLK: assert property (state.pll_src == pin_mux_pkg::PLL_MCLK |=>
        o_pll_ref == $past(i_mclk_pin))
        else $error("pll reference not from master clock");
    AST_POWER_WRITE: assert property (i_cfg_write |=>
        o_analog_power_en == $past(i_cfg_power_up))
        else $error("power enables not updated");
    AST_MIC_DATA_IDLE: assert property (
        state.din_func != pin_mux_pkg::DIN_MIC_DATA
        && state.three_func != pin_mux_pkg::THREE_MIC_DATA
        && state.gpio_func != pin_mux_pkg::GPIO_MIC_DATA |=> !o_mic_data)
        else $error("mic data active while unassigned");
    AST_MIC_CLK_OUT: assert property (seq_mic_clk_on_four |=>
        !o_four_oe_n && o_four_pin == $past(i_mic_clk))
        else $error("mic clock not driven on pin");
    AST_SEC_BCLK: assert property (
        state.gpio_func == pin_mux_pkg::GPIO_SEC_BCLK
        && state.three_func != pin_mux_pkg::THREE_SEC_BCLK |=> o_sec_bclk == $past(i_gpio_pin))
        else $error("secondary bit clock not from gp pin");
    AST_GPO_GPIO: assert property (state.gpio_func == pin_mux_pkg::GPIO_GPO |=>
        !o_gpio_oe_n && o_gpio_pin == $past(state.gpo_level[pin_mux_pkg::GPO_GPIO_BIT]))
        else $error("gp output level wrong");
    AST_EXCLUSIVE_DIN: assert property (state.din_func != pin_mux_pkg::DIN_AUDIO |=>
        !o_audio_din)
        else $error("audio data leaks from reassigned pin");

endmodule // multifunction_pin_mux

`default_nettype wire

//--- verification/pin_peer_model.sv
// Far-side pin model: pin stimulus patterns and the shared general-purpose pin wire
`timescale 1ns/1ps
`default_nettype none

module pin_peer_model (
    input  wire logic i_clk,
    input  wire logic i_reset,
    input  wire logic i_gp_level,
    input  wire logic i_gp_oe_n,
    output logic      o_mclk,
    output logic      o_bclk,
    output logic      o_sdin,
    output logic      o_pin_three,
    output logic      o_gp_wire,
    output logic      o_ctl_clk,
    output logic      o_ctl_data
);
    logic [3:0] cnt;

    ////////////////////////////////////////////////////////////////////////////
    // Distinct patterns, all changing just after the rising edge
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            cnt <= 4'h0;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end

    assign o_mclk      = cnt[0];
    assign o_bclk      = cnt[0] ^ cnt[1];
    assign o_sdin      = cnt[0] ^ cnt[2];
    assign o_pin_three = cnt[0] ^ cnt[3];
    assign o_ctl_clk   = cnt[1];
    assign o_ctl_data  = cnt[1] ^ cnt[2];

    ////////////////////////////////////////////////////////////////////////////
    // Released pin shows a changing pattern, never the last driven level
    assign o_gp_wire   = i_gp_oe_n ? ~(cnt[0] ^ cnt[1] ^ cnt[2]) : i_gp_level;
endmodule // pin_peer_model

`default_nettype wire

//--- verification/multifunction_pin_mux_test.sv
// Self-checking testbench for the digital pin multiplexer
`timescale 1ns/1ps
`default_nettype none

module multifunction_pin_mux_test;
    localparam int IN_MCLK = 0, IN_BCLK = 1, IN_SDIN = 2, IN_THREE = 3, IN_GP = 4;
    localparam int IN_AUD = 5, IN_MCK = 6, IN_CC = 7, IN_CD = 8;
    localparam int OUT_SCL = 0, OUT_SDA = 1, OUT_CS = 2, OUT_MOSI = 3, OUT_PLL = 4, OUT_ADIN = 5;
    localparam int OUT_MIC = 6, OUT_SEC = 7, OUT_SDOUT = 8, OUT_FOUR = 9, OUT_GP = 10;

    logic clk, reset, reset_pin_n, spi_select, cfg_write, audio_dout, mic_clk;
    logic mclk, bclk, sdin, pin_three, gp_w, ctl_clk, ctl_data, i2c_mode;
    logic scl, sda, cs_n, mosi, pll_ref, audio_din, mic_data, sec_bclk;
    logic dout_pin, dout_oe_n, four_pin, four_oe_n, gp_pin, gp_oe_n;
    logic [3:0] power_en;
    int         n_mismatch = 0;
    int         checked = 0;
    pin_mux_pkg::din_func_t  s_din,  din_f  = pin_mux_pkg::DIN_FUNC_RESET;
    pin_mux_pkg::dout_func_t s_dout, dout_f = pin_mux_pkg::DOUT_FUNC_RESET;
    pin_mux_pkg::three_func_t s_thr, thr_f  = pin_mux_pkg::THREE_FUNC_RESET;
    pin_mux_pkg::four_func_t s_four, four_f = pin_mux_pkg::FOUR_FUNC_RESET;
    pin_mux_pkg::gpio_func_t s_gp,   gp_f   = pin_mux_pkg::GPIO_FUNC_RESET;
    pin_mux_pkg::pll_src_t   s_pll,  pll_f  = pin_mux_pkg::PLL_SRC_RESET;
    logic [2:0]              s_lvl,  lvl_f  = 3'h0;
    logic [3:0]              s_pwr,  pwr_f  = 4'h0;
    wire  [8:0]  ins  = {ctl_data, ctl_clk, mic_clk, audio_dout, gp_w, pin_three, sdin, bclk,
                         mclk};
    wire  [10:0] outs = {gp_pin, four_pin, dout_pin, sec_bclk, mic_data, audio_din, pll_ref,
                         mosi, cs_n, sda, scl};

    multifunction_pin_mux i_multifunction_pin_mux (
        .i_clk(clk), .i_reset(reset), .i_reset_pin_n(reset_pin_n), .i_spi_select(spi_select),
        .i_ctl_clk_pin(ctl_clk), .i_ctl_data_pin(ctl_data), .i_cfg_write(cfg_write),
        .i_cfg_din_func(din_f), .i_cfg_dout_func(dout_f), .i_cfg_three_func(thr_f),
        .i_cfg_four_func(four_f), .i_cfg_gpio_func(gp_f), .i_cfg_pll_src(pll_f),
        .i_cfg_gpo_level(lvl_f), .i_cfg_power_up(pwr_f), .i_mclk_pin(mclk), .i_bclk_pin(bclk),
        .i_din_pin(sdin), .i_three_pin(pin_three), .i_gpio_pin(gp_w), .i_audio_dout(audio_dout),
        .i_mic_clk(mic_clk), .o_i2c_mode(i2c_mode), .o_i2c_scl(scl), .o_i2c_sda(sda),
        .o_serial_port_chip_select_n(cs_n), .o_spi_mosi(mosi), .o_pll_ref(pll_ref),
        .o_audio_din(audio_din), .o_mic_data(mic_data), .o_sec_bclk(sec_bclk),
        .o_dout_pin(dout_pin), .o_dout_oe_n(dout_oe_n), .o_four_pin(four_pin),
        .o_four_oe_n(four_oe_n), .o_gpio_pin(gp_pin), .o_gpio_oe_n(gp_oe_n),
        .o_analog_power_en(power_en));

    pin_peer_model i_pin_peer_model (
        .i_clk(clk), .i_reset(reset), .i_gp_level(gp_pin), .i_gp_oe_n(gp_oe_n), .o_mclk(mclk),
        .o_bclk(bclk), .o_sdin(sdin), .o_pin_three(pin_three), .o_gp_wire(gp_w),
        .o_ctl_clk(ctl_clk), .o_ctl_data(ctl_data));

    ////////////////////////////////////////////////////////////////////////////
    // Clock and core-side data
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk) audio_dout <= ~audio_dout;
    always @(posedge clk) if (audio_dout) mic_clk <= ~mic_clk;

    ////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        if (n_mismatch == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic follow(input int o, input int i);
        logic e;
        @(negedge clk);
        e = ins[i];
        repeat (12) begin
            @(negedge clk);
            chk(outs[o], e);
            e = ins[i];
        end
    endtask

    task automatic defaults();
        s_din  = pin_mux_pkg::DIN_FUNC_RESET;
        s_dout = pin_mux_pkg::DOUT_FUNC_RESET;
        s_thr  = pin_mux_pkg::THREE_FUNC_RESET;
        s_four = pin_mux_pkg::FOUR_FUNC_RESET;
        s_gp   = pin_mux_pkg::GPIO_FUNC_RESET;
        s_pll  = pin_mux_pkg::PLL_SRC_RESET;
        s_lvl  = pin_mux_pkg::GPO_LEVEL_RESET;
        s_pwr  = 4'h0;
    endtask

    task automatic wr();
        @(posedge clk);
        din_f     <= s_din;
        dout_f    <= s_dout;
        thr_f     <= s_thr;
        four_f    <= s_four;
        gp_f      <= s_gp;
        pll_f     <= s_pll;
        lvl_f     <= s_lvl;
        pwr_f     <= s_pwr;
        cfg_write <= 1'b1;
        @(posedge clk);
        cfg_write <= 1'b0;
        @(posedge clk);
        @(negedge clk);
    endtask

    task automatic edges();
        @(posedge clk);
        @(posedge clk);
        @(negedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_defaults();
        chk(i2c_mode, 1'b1);
        chk({cs_n, mosi}, 2'h2);
        chk(power_en, 4'h0);
        chk({dout_oe_n, four_oe_n, gp_oe_n}, 3'h3);
        chk({mic_data, sec_bclk}, 2'h0);
        follow(OUT_SCL, IN_CC);
        follow(OUT_SDOUT, IN_AUD);
        follow(OUT_ADIN, IN_SDIN);
    endtask

    task automatic t_select();
        @(posedge clk);
        spi_select <= 1'b1;
        edges();
        chk(i2c_mode, 1'b0);
        chk({scl, sda}, 2'h3);
        follow(OUT_CS, IN_CC);
        s_gp = pin_mux_pkg::GPIO_GPO;
        wr();
        chk(i2c_mode, 1'b0);
        follow(OUT_MOSI, IN_CD);
        @(posedge clk);
        spi_select <= 1'b0;
        edges();
        follow(OUT_SDA, IN_CD);
    endtask

    task automatic t_pll();
        for (int k = 0; k < 4; k++) begin
            defaults();
            s_pll = pin_mux_pkg::pll_src_t'(4'h1 << k);
            if (k == 2) s_din = pin_mux_pkg::DIN_PLL_REF;
            if (k == 3) s_gp = pin_mux_pkg::GPIO_PLL_REF;
            wr();
            follow(OUT_PLL, (k == 3) ? IN_GP : k);
            if (k == 2) begin
                repeat (4) begin
                    @(negedge clk);
                    chk(audio_din, 1'b0);
                end
            end
        end
        defaults();
        s_pll = pin_mux_pkg::PLL_DIN;
        wr();
        repeat (4) begin
            @(negedge clk);
            chk(pll_ref, 1'b0);
        end
    endtask

    task automatic t_mic();
        defaults();
        s_din = pin_mux_pkg::DIN_MIC_DATA;
        wr();
        follow(OUT_MIC, IN_SDIN);
        s_din = pin_mux_pkg::DIN_AUDIO;
        s_thr = pin_mux_pkg::THREE_MIC_DATA;
        s_four = pin_mux_pkg::FOUR_MIC_CLK;
        wr();
        follow(OUT_MIC, IN_THREE);
        chk(four_oe_n, 1'b0);
        follow(OUT_FOUR, IN_MCK);
        s_thr = pin_mux_pkg::THREE_SEC_BCLK;
        s_gp = pin_mux_pkg::GPIO_MIC_DATA;
        wr();
        follow(OUT_SEC, IN_THREE);
        follow(OUT_MIC, IN_GP);
        defaults();
        s_gp = pin_mux_pkg::GPIO_SEC_BCLK;
        wr();
        chk(mic_data, 1'b0);
        follow(OUT_SEC, IN_GP);
        s_gp = pin_mux_pkg::GPIO_MIC_CLK;
        wr();
        chk({gp_oe_n, four_oe_n}, 2'h1);
        follow(OUT_GP, IN_MCK);
    endtask

    task automatic t_outputs();
        defaults();
        s_dout = pin_mux_pkg::DOUT_GPO;
        s_four = pin_mux_pkg::FOUR_GPO;
        s_gp = pin_mux_pkg::GPIO_GPO;
        for (int v = 0; v < 8; v += 5) begin
            s_lvl = 3'h5 ^ 3'(v);
            wr();
            chk({dout_oe_n, four_oe_n, gp_oe_n}, 3'h0);
            repeat (3) begin
                @(negedge clk);
                chk({gp_pin, four_pin, dout_pin}, s_lvl);
            end
        end
        s_pwr = 4'h5;
        wr();
        chk(power_en, 4'h5);
        s_pwr = 4'hA;
        wr();
        chk(power_en, 4'hA);
    endtask

    task automatic t_refused();
        defaults();
        s_gp = pin_mux_pkg::GPIO_GPO;
        s_pwr = 4'hF;
        wr();
        s_gp = pin_mux_pkg::gpio_func_t'(6'h03);
        s_four = pin_mux_pkg::FOUR_GPO;
        s_lvl = 3'h6;
        wr();
        chk({gp_oe_n, gp_pin}, 2'h1);
        chk({four_oe_n, four_pin}, 2'h1);
        @(posedge clk);
        reset_pin_n <= 1'b0;
        @(posedge clk);
        reset_pin_n <= 1'b1;
        edges();
        chk({gp_oe_n, four_oe_n, power_en}, 6'h30);
        follow(OUT_PLL, IN_MCLK);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence and watchdog
    initial begin
        reset = 1'b1;
        reset_pin_n = 1'b1;
        spi_select = 1'b0;
        cfg_write = 1'b0;
        audio_dout = 1'b0;
        mic_clk = 1'b0;
        defaults();
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        t_defaults();
        t_select();
        t_pll();
        t_mic();
        t_outputs();
        t_refused();
        conclude();
    end

    initial begin
        #100000;
        n_mismatch++;
        conclude();
    end
endmodule // multifunction_pin_mux_test

`default_nettype wire
